// >>> rtl/tx_bias_params.svh
// Register indices, field positions, reset values and bias limits
`ifndef TX_BIAS_PARAMS_SVH
`define TX_BIAS_PARAMS_SVH

`define IDX_AMP_EQ 5'h0B
`define IDX_MOD_LEVEL 5'h0C
`define IDX_SHAPING 5'h0D
`define IDX_XPOINT 5'h0E
`define IDX_BIAS_HIGH 5'h0F

`define REG_RESET 8'h00
`define UNMAPPED_READ 8'h00

`define AMP_RANGE_BIT 7
`define PEAK_BIT 6
`define TCOMP_HI 5
`define TCOMP_LO 4
`define EQ_HI 3
`define EQ_LO 0

`define LEG_BIT 7
`define SE_BIT 6
`define DEEMPH_DLY_BIT 5
`define SLOW_BIT 4
`define DEEMPH_HI 3
`define DEEMPH_LO 0

`define XP_DIR_BIT 7
`define XP_MAG_HI 6
`define XP_MAG_LO 0

`define PD_RANGE_3UA_BIT 1
`define PD_RANGE_1P5UA 2'h1

// Open-loop step and ceiling, in microamps
`define BIAS_MAX_UA 150000
`define OPEN_STEP_UA 147
`define OPEN_CODE_MAX (`BIAS_MAX_UA / `OPEN_STEP_UA)

`endif

// >>> rtl/tx_bias_pkg.sv
// Types shared by the transmit control register bank
package tx_bias_pkg;

    typedef enum logic [1:0] {
        UNIT_0P75_UA,
        UNIT_1P5_UA,
        UNIT_3_UA
    } pd_unit_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic open_loop_en;
        logic [1:0] pd_range_sel;
        logic bias_sink_sel;
        logic [1:0] bias_code_lsbs;
    } bias_cfg_t;

    typedef struct packed {
        logic amp_range_half;
        logic peaking_width_sel;
        logic [1:0] temp_comp_sel;
        logic [3:0] input_eq_level;
        logic [7:0] mod_level_code;
        logic output_leg_sel;
        logic single_ended_sel;
        logic deemph_delayed_sel;
        logic slow_edge_sel;
        logic [3:0] deemph_level;
        logic crosspoint_dir;
        logic [6:0] crosspoint_mag;
    } drive_ctrl_t;

    typedef struct packed {
        logic open_loop;
        logic sink;
        pd_unit_t unit;
        logic [9:0] bias_code;
        logic clamped;
    } bias_ctrl_t;

    typedef struct packed {
        logic [7:0] amp_eq_reg;
        logic [7:0] mod_level_reg;
        logic [7:0] shaping_reg;
        logic [7:0] xpoint_reg;
        logic [7:0] bias_high_reg;
        logic [7:0] rdata_reg;
        bias_ctrl_t bias_reg;
    } bank_state_t;

endpackage

// >>> rtl/tx_output_bias_ctrl_regs.sv
// Transmit amplitude, shaping and bias-high control registers
`timescale 1ns/100ps
`include "tx_bias_params.svh"

module tx_output_bias_ctrl_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire tx_bias_pkg::reg_req_t req,
    input wire tx_bias_pkg::bias_cfg_t bias_cfg,
    output tx_bias_pkg::drive_ctrl_t drive,
    output tx_bias_pkg::bias_ctrl_t bias,
    output logic [7:0] rdata
);
    import tx_bias_pkg::*;

    localparam logic [9:0] OPEN_CODE_MAX = 10'(`OPEN_CODE_MAX);

    bank_state_t state_reg;
    bank_state_t state_next;
    logic [9:0] code_full;

    always_comb begin
        state_next = state_reg;
        // Write lands at the next edge; no other access side effects
        if (req.wr) begin
            if (req.addr == `IDX_AMP_EQ) begin
                state_next.amp_eq_reg = req.wdata;
            end else if (req.addr == `IDX_MOD_LEVEL) begin
                state_next.mod_level_reg = req.wdata;
            end else if (req.addr == `IDX_SHAPING) begin
                state_next.shaping_reg = req.wdata;
            end else if (req.addr == `IDX_XPOINT) begin
                state_next.xpoint_reg = req.wdata;
            end else if (req.addr == `IDX_BIAS_HIGH) begin
                state_next.bias_high_reg = req.wdata;
            end
        end
        // Read returns the value held before any same-cycle write
        if (req.rd) begin
            if (req.addr == `IDX_AMP_EQ) begin
                state_next.rdata_reg = state_reg.amp_eq_reg;
            end else if (req.addr == `IDX_MOD_LEVEL) begin
                state_next.rdata_reg = state_reg.mod_level_reg;
            end else if (req.addr == `IDX_SHAPING) begin
                state_next.rdata_reg = state_reg.shaping_reg;
            end else if (req.addr == `IDX_XPOINT) begin
                state_next.rdata_reg = state_reg.xpoint_reg;
            end else if (req.addr == `IDX_BIAS_HIGH) begin
                state_next.rdata_reg = state_reg.bias_high_reg;
            end else begin
                state_next.rdata_reg = `UNMAPPED_READ;
            end
        end
        // Ten-bit code rebuilt every cycle from both halves, so a
        // split update shows a partial code until both halves are set; the
        // upper half is taken after this cycle's write so the code
        // follows a write one cycle later, like the other fields
        code_full = {state_next.bias_high_reg,
                     bias_cfg.bias_code_lsbs};
        state_next.bias_reg.open_loop = bias_cfg.open_loop_en;
        state_next.bias_reg.sink = bias_cfg.bias_sink_sel;
        if (bias_cfg.pd_range_sel[`PD_RANGE_3UA_BIT]) begin
            state_next.bias_reg.unit = UNIT_3_UA;
        end else if (bias_cfg.pd_range_sel == `PD_RANGE_1P5UA) begin
            state_next.bias_reg.unit = UNIT_1P5_UA;
        end else begin
            state_next.bias_reg.unit = UNIT_0P75_UA;
        end
        // Open loop step is fixed, so the current ceiling maps to a
        // code ceiling; closed loop depends on the coupling ratio,
        // which only the analog loop knows, so the code passes through
        if (bias_cfg.open_loop_en && code_full > OPEN_CODE_MAX) begin
            state_next.bias_reg.bias_code = OPEN_CODE_MAX;
            state_next.bias_reg.clamped = 1'b1;
        end else begin
            state_next.bias_reg.bias_code = code_full;
            state_next.bias_reg.clamped = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.amp_eq_reg <= `REG_RESET;
            state_reg.mod_level_reg <= `REG_RESET;
            state_reg.shaping_reg <= `REG_RESET;
            state_reg.xpoint_reg <= `REG_RESET;
            state_reg.bias_high_reg <= `REG_RESET;
            state_reg.rdata_reg <= `REG_RESET;
            state_reg.bias_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        drive.amp_range_half = state_reg.amp_eq_reg[`AMP_RANGE_BIT];
        drive.peaking_width_sel = state_reg.amp_eq_reg[`PEAK_BIT];
        drive.temp_comp_sel =
            state_reg.amp_eq_reg[`TCOMP_HI:`TCOMP_LO];
        drive.input_eq_level = state_reg.amp_eq_reg[`EQ_HI:`EQ_LO];
        drive.mod_level_code = state_reg.mod_level_reg;
        drive.output_leg_sel = state_reg.shaping_reg[`LEG_BIT];
        drive.single_ended_sel = state_reg.shaping_reg[`SE_BIT];
        drive.deemph_delayed_sel =
            state_reg.shaping_reg[`DEEMPH_DLY_BIT];
        drive.slow_edge_sel = state_reg.shaping_reg[`SLOW_BIT];
        drive.deemph_level =
            state_reg.shaping_reg[`DEEMPH_HI:`DEEMPH_LO];
        drive.crosspoint_dir = state_reg.xpoint_reg[`XP_DIR_BIT];
        drive.crosspoint_mag =
            state_reg.xpoint_reg[`XP_MAG_HI:`XP_MAG_LO];
        bias = state_reg.bias_reg;
        rdata = state_reg.rdata_reg;
    end

endmodule

// >>> sim/tx_bias_chk.sv
// Port checker for the transmit control register bank
`timescale 1ns/100ps
module tx_bias_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire tx_bias_pkg::reg_req_t req,
    input wire tx_bias_pkg::bias_cfg_t bias_cfg,
    input wire tx_bias_pkg::drive_ctrl_t drive,
    input wire tx_bias_pkg::bias_ctrl_t bias,
    input wire logic [7:0] rdata
);
    import tx_bias_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_amp; req.wr && req.addr == 5'h0B |=>
        drive[31:24] == $past(req.wdata); endproperty
    a_amp: assert property (p_amp) else $error("amp reg");
    property p_shp; req.wr && req.addr == 5'h0D |=>
        drive[15:8] == $past(req.wdata); endproperty
    a_shp: assert property (p_shp) else $error("shaping reg");
    property p_xp; req.wr && req.addr == 5'h0E |=>
        drive[7:0] == $past(req.wdata); endproperty
    a_xp: assert property (p_xp) else $error("crosspoint reg");
    property p_bh; req.wr && req.addr == 5'h0F && !bias_cfg.open_loop_en |=>
        bias.bias_code[9:2] == $past(req.wdata); endproperty
    a_bh: assert property (p_bh) else $error("bias high");
    property p_cl; bias_cfg.open_loop_en |=>
        bias.bias_code <= 10'd1020; endproperty
    a_cl: assert property (p_cl) else $error("open loop clamp");
    property p_cfg; 1'b1 |=> {bias.open_loop, bias.sink} ==
        $past({bias_cfg.open_loop_en, bias_cfg.bias_sink_sel}); endproperty
    a_cfg: assert property (p_cfg) else $error("bias mode");
    property p_rd; req.rd && !req.wr && req.addr == 5'h0E |=>
        rdata == $past(drive[7:0]); endproperty
    a_rd: assert property (p_rd) else $error("read back");
    property p_unm; req.rd && req.addr > 5'h0F |=>
        rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    c_clamp: cover property (bias.clamped);
    c_unm: cover property (req.rd && req.addr > 5'h0F);
    c_bh: cover property (req.wr && req.addr == 5'h0F);
endmodule
bind tx_output_bias_ctrl_regs tx_bias_chk u_chk (.clk(clk), .rst_n(rst_n),
    .req(req), .bias_cfg(bias_cfg), .drive(drive), .bias(bias), .rdata(rdata));

// >>> sim/testbench.sv
// Self-checking bench for the transmit control register bank
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import tx_bias_pkg::*;
    logic clk;
    logic rst_n;
    reg_req_t req;
    bias_cfg_t bias_cfg;
    drive_ctrl_t drive;
    bias_ctrl_t bias;
    logic [7:0] rdata;
    int num_errors = 0;
    int num_checks = 0;
    typedef struct packed {logic [4:0] a; logic [7:0] d;} row_t;
    row_t rows [5] = '{'{5'h0B, 8'hA5}, '{5'h0C, 8'hFF}, '{5'h0D, 8'h90},
        '{5'h0E, 8'h7F}, '{5'h0F, 8'h81}};
    tx_output_bias_ctrl_regs u_dut (.clk(clk), .rst_n(rst_n), .req(req),
        .bias_cfg(bias_cfg), .drive(drive), .bias(bias), .rdata(rdata));
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // One strobe cycle, then idle so the next request sees a clean edge
    task automatic op(input logic w, input logic r, input logic [4:0] a,
            input logic [7:0] d);
        @(posedge clk);
        #5 req = '{w, r, a, d};
        @(posedge clk);
        #5 req = '0;
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        num_errors++;
        test_done();
    end
    initial begin
        req = '0;
        bias_cfg = '0;
        rst_n = 0;
        repeat (16) @(posedge clk);
        #5 rst_n = 1;
        for (int i = 11; i < 16; i++) begin
            op(0, 1, 5'(i), 8'h00);
            `CHK(rdata, 8'h00)
        end
        `CHK({drive, bias}, '0)
        foreach (rows[i]) begin
            op(1, 0, rows[i].a, rows[i].d);
            op(0, 1, rows[i].a, 8'h00);
            `CHK(rdata, rows[i].d)
        end
        `CHK({drive, bias.bias_code[9:2]}, 40'hA5FF907F81)
        op(1, 0, 5'h0A, 8'h55);
        `CHK(drive, 32'hA5FF907F)
        op(0, 1, 5'h10, 8'h00);
        `CHK(rdata, 8'h00)
        bias_cfg = '{1'b0, 2'h0, 1'b1, 2'h3};
        op(1, 0, 5'h0F, 8'hFF);
        `CHK({bias.sink, bias.clamped, bias.bias_code}, 12'hBFF)
        bias_cfg.open_loop_en = 1;
        @(posedge clk);
        #5 `CHK({bias.open_loop, bias.clamped, bias.bias_code}, 12'hFFC)
        for (int i = 0; i < 4; i++) begin
            bias_cfg.pd_range_sel = 2'(i);
            @(posedge clk);
            #5 `CHK(bias.unit, i > 1 ? UNIT_3_UA : pd_unit_t'(i))
        end
        // Low bias half set first, then the upper half written, so the code passes through 0x3FD for one cycle
        bias_cfg = '{1'b0, 2'h0, 1'b0, 2'h1};
        op(1, 0, 5'h0F, 8'h12);
        `CHK({bias.open_loop, bias.bias_code}, 11'h049)
        // Read and write in one cycle: read sees the old value
        op(1, 1, 5'h0C, 8'h3C);
        `CHK(rdata, 8'hFF)
        `CHK(drive.mod_level_code, 8'h3C)
        // Reset in mid-run clears every output at once
        @(posedge clk);
        #5 rst_n = 0;
        #1 `CHK({drive, bias, rdata}, '0)
        repeat (16) @(posedge clk);
        #5 rst_n = 1;
        op(0, 1, 5'h0C, 8'h00);
        `CHK({rdata, drive}, '0)
        test_done();
    end
endmodule
